/* File: shared/ses_consts.vh */
// constants for the status event summary block: offsets, fields, resets
// assumes a byte-addressed Avalon-MM slave with 32-bit words
`ifndef SES_CONSTS_VH
`define SES_CONSTS_VH

// register byte offsets
`define SES_OPER_COND 6'h00
`define SES_OPER_RISE 6'h04
`define SES_OPER_FALL 6'h08
`define SES_OPER_EVENT 6'h0C
`define SES_OPER_ENAB 6'h10
`define SES_QUES_COND 6'h14
`define SES_QUES_RISE 6'h18
`define SES_QUES_FALL 6'h1C
`define SES_QUES_EVENT 6'h20
`define SES_QUES_ENAB 6'h24
`define SES_STB 6'h28
`define SES_SRE 6'h2C
`define SES_CTRL 6'h30
`define SES_IRQ_STAT 6'h34
`define SES_IRQ_MASK 6'h38

// control register fields (write-only strobes)
`define SES_CTRL_CLS 0
`define SES_CTRL_PRESET 1

// status byte field positions
`define SES_STB_QUES 3
`define SES_STB_MAV 4
`define SES_STB_RQS 6
`define SES_STB_OPER 7

// interrupt status fields
`define SES_IRQ_OPER 0
`define SES_IRQ_QUES 1
`define SES_IRQ_SRQ 2

// reset values
`define SES_RISE_RESET 16'h7FFF
`define SES_FALL_RESET 16'h0000
`define SES_ENAB_RESET 16'h0000
`define SES_SRE_RESET 8'h00
`define SES_GROUP_MASK 16'h7FFF

`endif

/* File: src/ses_group.v */
// one 16-bit status group: condition, transition filter, event, enable
// assumes condition inputs already synchronised to clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "ses_consts.vh"

module ses_group (
    input wire clk_sys,
    input wire rstn,
    input wire [15:0] condIn,
    input wire [15:0] riseMaskIn,
    input wire [15:0] fallMaskIn,
    input wire [15:0] enableIn,
    input wire clearEvent,
    output wire [15:0] condOut,
    output reg [15:0] eventBits,
    output reg summary
);
    reg [15:0] condPrev;
    wire [15:0] hits;
    wire [15:0] next_event;

    // live condition, bit 15 forced low
    assign condOut = condIn & `SES_GROUP_MASK;
    // edge detect against last cycle, filtered per bit
    assign hits = ((condOut & ~condPrev & riseMaskIn)
                 | (~condOut & condPrev & fallMaskIn)) & `SES_GROUP_MASK;
    // new hits win over a clear in the same cycle
    assign next_event = (clearEvent ? 16'h0000 : eventBits) | hits;

    // event latch and summary
    always @(posedge clk_sys) begin
        if (!rstn) begin
            condPrev <= 16'h0000;
            eventBits <= 16'h0000;
            summary <= 1'b0;
        end else begin
            condPrev <= condOut;
            eventBits <= next_event;
            summary <= |(next_event & enableIn);
        end
    end
endmodule
`default_nettype wire

/* File: src/ses_sync.v */
// two-flop synchroniser for a bus of pin-level inputs
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none

module ses_sync (
    input wire clk_sys,
    input wire rstn,
    input wire [32:0] async,
    output reg [32:0] synced
);
    reg [32:0] meta;

    // first stage feeds only the second
    always @(posedge clk_sys) begin
        if (!rstn) begin
            meta <= 33'h0;
            synced <= 33'h0;
        end else begin
            meta <= async;
            synced <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: src/ses_top.v */
// status event summary: two 16-bit status groups, status byte, service request
// assumes an Avalon-MM master on clk_sys; condition and queue pins are asynchronous
// assumes the master holds each request until waitrequest is seen low
// unmapped offsets read zero; writes to read-only offsets are dropped
// preset reloads only the transition filters of both groups
// interrupt status bits are sticky and cleared by writing ones
//
// What this block does
// - condition registers are live and read-only
// - rising/falling masks select which edges set events
// - transition masks read-write, untouched by clear/query
// - preset: falling mask zero, rising mask all ones
// - event bits stay latched until group cleared
// - event cleared by read or clear-status, not writable
// - summary is OR of event AND enable
// - enable masks read-write, reads leave unchanged
// - every group holds all four registers
// - enabled status byte bit raises service request
// - status byte bit 4 flags output message waiting
// - enable query returns weighted sum of bits
// - read data only when the controller queries; service request and irq raised unprompted
// - bit 15 of each group reads zero
// - clearing event clears its status byte summary
`timescale 1ns/1ps
`default_nettype none
`include "ses_consts.vh"

module ses_top (
    input wire clk_sys,
    input wire rstn,
    input wire [5:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    input wire [3:0] avsByteEnable,
    output reg [31:0] avsReadData,
    output reg avsWaitRequest,
    input wire [15:0] operCondPin,
    input wire [15:0] quesCondPin,
    input wire msgWaitingPin,
    output reg serviceRequest,
    output reg irq
);
    // synchronised pins
    wire [32:0] pinsSynced;
    wire [15:0] operCond;
    wire [15:0] quesCond;
    wire msgWaiting;

    // software-visible state
    reg [15:0] operRise;
    reg [15:0] operFall;
    reg [15:0] operEnab;
    reg [15:0] quesRise;
    reg [15:0] quesFall;
    reg [15:0] quesEnab;
    reg [7:0] srvEnable;
    reg [2:0] irqStat;
    reg [2:0] irqMask;

    // bus handshake state
    reg accessDone;
    wire accessNow;
    wire wrNow;
    wire rdNow;

    // group outputs
    wire [15:0] operCondLive;
    wire [15:0] quesCondLive;
    wire [15:0] operEvent;
    wire [15:0] quesEvent;
    wire operSummary;
    wire quesSummary;
    reg clearOper;
    reg clearQues;

    // status byte
    wire [7:0] statusByte;
    wire [7:0] statusNoRqs;
    wire next_serviceRequest;
    reg [2:0] next_irqStat;
    reg [31:0] next_readData;
    reg srqPrev;

    // decoded strobes of the accepted access
    wire wrOperRise;
    wire wrOperFall;
    wire wrOperEnab;
    wire wrQuesRise;
    wire wrQuesFall;
    wire wrQuesEnab;
    wire wrSre;
    wire wrCtrl;
    wire wrIrqStat;
    wire wrIrqMask;
    wire rdOperEvent;
    wire rdQuesEvent;
    wire clsNow;
    wire presetNow;

    // byte-lane merge of a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] be;
        begin
            merge16[7:0] = be[0] ? data[7:0] : old[7:0];
            merge16[15:8] = be[1] ? data[15:8] : old[15:8];
            merge16 = merge16 & `SES_GROUP_MASK;
        end
    endfunction

    // strobe when the accepted access targets one offset
    function hitAt;
        input [5:0] addr;
        input [5:0] offset;
        input strobe;
        begin
            hitAt = strobe && (addr == offset);
        end
    endfunction

    // a 16-bit register on the 32-bit read bus, upper half zero
    function [31:0] pad16;
        input [15:0] value;
        begin
            pad16 = {16'h0000, value};
        end
    endfunction

    // all pin inputs pass two flip-flops first
    ses_sync uSync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .async({msgWaitingPin, quesCondPin, operCondPin}),
        .synced(pinsSynced)
    );
    assign operCond = pinsSynced[15:0];
    assign quesCond = pinsSynced[31:16];
    assign msgWaiting = pinsSynced[32];

    // one access per request: answer with waitrequest low one cycle later
    assign accessNow = (avsRead | avsWrite) & ~accessDone;
    assign wrNow = avsWrite & ~accessDone;
    assign rdNow = avsRead & ~accessDone;

    // address decode, one strobe per writable register
    assign wrOperRise = hitAt(avsAddress, `SES_OPER_RISE, wrNow);
    assign wrOperFall = hitAt(avsAddress, `SES_OPER_FALL, wrNow);
    assign wrOperEnab = hitAt(avsAddress, `SES_OPER_ENAB, wrNow);
    assign wrQuesRise = hitAt(avsAddress, `SES_QUES_RISE, wrNow);
    assign wrQuesFall = hitAt(avsAddress, `SES_QUES_FALL, wrNow);
    assign wrQuesEnab = hitAt(avsAddress, `SES_QUES_ENAB, wrNow);
    assign wrSre = hitAt(avsAddress, `SES_SRE, wrNow);
    assign wrCtrl = hitAt(avsAddress, `SES_CTRL, wrNow);
    assign wrIrqStat = hitAt(avsAddress, `SES_IRQ_STAT, wrNow);
    assign wrIrqMask = hitAt(avsAddress, `SES_IRQ_MASK, wrNow);
    // a read of an event register clears it
    assign rdOperEvent = hitAt(avsAddress, `SES_OPER_EVENT, rdNow);
    assign rdQuesEvent = hitAt(avsAddress, `SES_QUES_EVENT, rdNow);
    // control strobes on byte lane 0; the register itself stores nothing
    assign clsNow = wrCtrl && avsByteEnable[0] && avsWriteData[`SES_CTRL_CLS];
    assign presetNow = wrCtrl && avsByteEnable[0] && avsWriteData[`SES_CTRL_PRESET];

    // event clear strobes: read of the event register or clear-status
    always @* begin
        clearOper = 1'b0;
        clearQues = 1'b0;
        if (rdOperEvent || clsNow) begin
            clearOper = 1'b1;
        end
        if (rdQuesEvent || clsNow) begin
            clearQues = 1'b1;
        end
    end

    // each group has condition, filter, event and enable
    ses_group uOper (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .condIn(operCond),
        .riseMaskIn(operRise),
        .fallMaskIn(operFall),
        .enableIn(operEnab),
        .clearEvent(clearOper),
        .condOut(operCondLive),
        .eventBits(operEvent),
        .summary(operSummary)
    );

    // questionable group, same structure
    ses_group uQues (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .condIn(quesCond),
        .riseMaskIn(quesRise),
        .fallMaskIn(quesFall),
        .enableIn(quesEnab),
        .clearEvent(clearQues),
        .condOut(quesCondLive),
        .eventBits(quesEvent),
        .summary(quesSummary)
    );

    // status byte assembly; request-service bit derived from the others
    assign statusNoRqs = {operSummary, 1'b0, 1'b0, msgWaiting, quesSummary, 3'b000};
    assign next_serviceRequest = |(statusNoRqs & srvEnable & ~(8'h01 << `SES_STB_RQS));
    assign statusByte = statusNoRqs | ({7'h00, serviceRequest} << `SES_STB_RQS);

    // interrupt events: summaries while high and a rising service request
    always @* begin
        next_irqStat = irqStat;
        if (wrIrqStat && avsByteEnable[0]) begin
            next_irqStat = irqStat & ~avsWriteData[2:0];
        end
        if (operSummary) begin
            next_irqStat[`SES_IRQ_OPER] = 1'b1;
        end
        if (quesSummary) begin
            next_irqStat[`SES_IRQ_QUES] = 1'b1;
        end
        if (serviceRequest && !srqPrev) begin
            next_irqStat[`SES_IRQ_SRQ] = 1'b1;
        end
    end

    // read mux; reads never touch masks or enables
    always @* begin
        next_readData = 32'h00000000;
        case (avsAddress)
            `SES_OPER_COND: next_readData = pad16(operCondLive);
            `SES_OPER_RISE: next_readData = pad16(operRise);
            `SES_OPER_FALL: next_readData = pad16(operFall);
            `SES_OPER_EVENT: next_readData = pad16(operEvent);
            `SES_OPER_ENAB: next_readData = pad16(operEnab);
            `SES_QUES_COND: next_readData = pad16(quesCondLive);
            `SES_QUES_RISE: next_readData = pad16(quesRise);
            `SES_QUES_FALL: next_readData = pad16(quesFall);
            `SES_QUES_EVENT: next_readData = pad16(quesEvent);
            `SES_QUES_ENAB: next_readData = pad16(quesEnab);
            `SES_STB: next_readData = {24'h000000, statusByte};
            `SES_SRE: next_readData = {24'h000000, srvEnable};
            `SES_IRQ_STAT: next_readData = {29'h0000000, irqStat};
            `SES_IRQ_MASK: next_readData = {29'h0000000, irqMask};
            default: next_readData = 32'h00000000;
        endcase
    end

    // bus handshake and read data
    always @(posedge clk_sys) begin
        if (!rstn) begin
            accessDone <= 1'b0;
            avsWaitRequest <= 1'b1;
            avsReadData <= 32'h00000000;
        end else begin
            accessDone <= accessNow;
            avsWaitRequest <= ~accessNow;
            if (rdNow) begin
                avsReadData <= next_readData;
            end
        end
    end

    // operation group masks; condition and event offsets ignore writes
    always @(posedge clk_sys) begin
        if (!rstn) begin
            operRise <= `SES_RISE_RESET;
            operFall <= `SES_FALL_RESET;
            operEnab <= `SES_ENAB_RESET;
        end else begin
            if (presetNow) begin
                operFall <= `SES_FALL_RESET;
                operRise <= `SES_RISE_RESET;
            end
            if (wrOperRise) begin
                operRise <= merge16(operRise, avsWriteData, avsByteEnable);
            end
            if (wrOperFall) begin
                operFall <= merge16(operFall, avsWriteData, avsByteEnable);
            end
            if (wrOperEnab) begin
                operEnab <= merge16(operEnab, avsWriteData, avsByteEnable);
            end
        end
    end

    // questionable group masks; preset reloads the filter, not the enable
    always @(posedge clk_sys) begin
        if (!rstn) begin
            quesRise <= `SES_RISE_RESET;
            quesFall <= `SES_FALL_RESET;
            quesEnab <= `SES_ENAB_RESET;
        end else begin
            if (presetNow) begin
                quesFall <= `SES_FALL_RESET;
                quesRise <= `SES_RISE_RESET;
            end
            if (wrQuesRise) begin
                quesRise <= merge16(quesRise, avsWriteData, avsByteEnable);
            end
            if (wrQuesFall) begin
                quesFall <= merge16(quesFall, avsWriteData, avsByteEnable);
            end
            if (wrQuesEnab) begin
                quesEnab <= merge16(quesEnab, avsWriteData, avsByteEnable);
            end
        end
    end

    // service request enable and interrupt mask
    always @(posedge clk_sys) begin
        if (!rstn) begin
            srvEnable <= `SES_SRE_RESET;
            irqMask <= 3'h0;
        end else begin
            if (wrSre && avsByteEnable[0]) begin
                srvEnable <= avsWriteData[7:0] & ~(8'h01 << `SES_STB_RQS);
            end
            if (wrIrqMask && avsByteEnable[0]) begin
                irqMask <= avsWriteData[2:0];
            end
        end
    end

    // outputs straight from flip-flops
    always @(posedge clk_sys) begin
        if (!rstn) begin
            serviceRequest <= 1'b0;
            srqPrev <= 1'b0;
            irqStat <= 3'h0;
            irq <= 1'b0;
        end else begin
            serviceRequest <= next_serviceRequest;
            srqPrev <= serviceRequest;
            irqStat <= next_irqStat;
            irq <= |(next_irqStat & irqMask);
        end
    end
endmodule
`default_nettype wire

/* File: tb/ses_top_sva.sv */
// port checker for the status event summary top
// assumes it is bound to ses_top, one clock clk_sys, reset rstn
`timescale 1ns/1ps
`default_nettype none
`include "ses_consts.vh"
module ses_top_sva (
    input wire clk_sys,
    input wire rstn,
    input wire [5:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsReadData,
    input wire avsWaitRequest,
    input wire serviceRequest,
    input wire irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // bus answers: prompt, one cycle, only to a request
    a_wait_answer: assert property ($rose(avsRead || avsWrite) |-> ##[1:2] !avsWaitRequest)
        else $error("request not answered");
    a_wait_single: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("answer longer than one cycle");
    a_wait_cause: assert property (!avsWaitRequest |-> avsRead || avsWrite)
        else $error("answer without request");
    a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> avsWaitRequest && !irq && !serviceRequest)
        else $error("outputs active in reset");
    a_rdata_hold: assert property ($changed(avsReadData) |-> !avsWaitRequest && avsRead)
        else $error("read data moved outside a read");
    a_msb_zero: assert property (avsRead && !avsWaitRequest && avsAddress <= 6'h24 |-> !avsReadData[15])
        else $error("group bit 15 set");
    a_ctrl_zero: assert property (avsRead && !avsWaitRequest && avsAddress == `SES_CTRL |-> avsReadData == 32'h0)
        else $error("control reads nonzero");
    a_stb_width: assert property (avsRead && !avsWaitRequest && avsAddress == `SES_STB |-> avsReadData[31:8] == 24'h0)
        else $error("status byte too wide");
    c_irq: cover property ($rose(irq));
    c_srq: cover property ($rose(serviceRequest));
    c_read: cover property (avsRead && !avsWaitRequest);
endmodule
`default_nettype wire

/* File: tb/ses_host.sv */
// bus controller model: Avalon-MM master issuing one access at a time
// assumes the slave answers by dropping waitrequest for one cycle
`timescale 1ns/1ps
`default_nettype none
module ses_host (
    input wire clk_sys,
    input wire avsWaitRequest,
    input wire [31:0] avsReadData,
    output logic [5:0] avsAddress,
    output logic avsRead,
    output logic avsWrite,
    output logic [31:0] avsWriteData,
    output logic rdStrobe,
    output logic [31:0] rdWord
);
    initial begin
        avsAddress = 6'h00;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsWriteData = 32'h0;
        rdStrobe = 1'b0;
        rdWord = 32'h0;
    end
    // hold the request until waitrequest is sampled low, then release
    task automatic access(input logic wr, input logic [5:0] addr, input logic [31:0] data);
        @(posedge clk_sys);
        avsAddress <= addr;
        avsWriteData <= data;
        avsRead <= !wr;
        avsWrite <= wr;
        do @(posedge clk_sys); while (avsWaitRequest !== 1'b0);
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        rdStrobe <= !wr;
        rdWord <= avsReadData;
        @(posedge clk_sys);
        rdStrobe <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: tb/status_event_summary_tb.sv */
// self-checking bench for the status event summary top
// assumes ses_top, ses_host and ses_top_sva are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "ses_consts.vh"
module status_event_summary_tb;
    logic clk_sys, rstn, msgWaitingPin, rdStrobe, avsRead, avsWrite, avsWaitRequest;
    logic serviceRequest, irq;
    logic [15:0] operCondPin, quesCondPin, a, b, r, f;
    logic [5:0] avsAddress, gb;
    logic [31:0] avsWriteData, avsReadData, rdWord;
    logic [31:0] expQ[$];
    int n_mismatch = 0;
    int checks = 0;
    int seed = 97025;
    int g;
    ses_top u_ses_top (.clk_sys(clk_sys), .rstn(rstn), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(4'hF), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .operCondPin(operCondPin), .quesCondPin(quesCondPin), .msgWaitingPin(msgWaitingPin),
        .serviceRequest(serviceRequest), .irq(irq));
    ses_host u_ses_host (.clk_sys(clk_sys), .avsWaitRequest(avsWaitRequest),
        .avsReadData(avsReadData), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .rdStrobe(rdStrobe), .rdWord(rdWord));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("mismatches=%0d checks=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task wr(input logic [5:0] addr, input logic [31:0] data);
        u_ses_host.access(1'b1, addr, data);
    endtask
    task rd(input logic [5:0] addr, input logic [31:0] exp);
        expQ.push_back(exp);
        u_ses_host.access(1'b0, addr, 32'h0);
    endtask
    task pins(input logic [15:0] v);
        if (g == 1) quesCondPin <= v;
        else operCondPin <= v;
        repeat (5) @(posedge clk_sys);
    endtask
    // read results are compared against the oldest expectation
    always @(posedge clk_sys) if (rdStrobe === 1'b1) chk(rdWord, expQ.pop_front());
    initial begin
        #200000;
        n_mismatch++;
        complete_run;
    end
    initial begin
        rstn = 1'b0;
        msgWaitingPin = 1'b0;
        operCondPin = 16'h0;
        quesCondPin = 16'h0;
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(`SES_OPER_RISE, 32'h7FFF);
        rd(`SES_QUES_FALL, 32'h0);
        rd(`SES_OPER_ENAB, 32'h0);
        rd(6'h3C, 32'h0);
        wr(`SES_CTRL, 32'h1);
        // random transitions through the filter of each group
        for (g = 0; g < 2; g++) repeat (3) begin
            gb = (g == 1) ? 6'h14 : 6'h00;
            a = $random(seed);
            b = $random(seed);
            r = $random(seed);
            f = $random(seed);
            wr(gb + `SES_OPER_RISE, {16'h0, r});
            wr(gb + `SES_OPER_FALL, {16'h0, f});
            pins(a);
            wr(`SES_CTRL, 32'h1);
            rd(gb + `SES_OPER_EVENT, 32'h0);
            rd(gb + `SES_OPER_RISE, {17'h0, r[14:0]});
            rd(gb + `SES_OPER_FALL, {17'h0, f[14:0]});
            pins(b);
            rd(gb + `SES_OPER_COND, {17'h0, b[14:0]});
            wr(gb + `SES_OPER_COND, {16'h0, ~b});
            wr(gb + `SES_OPER_EVENT, 32'hFFFF);
            wr(gb + `SES_OPER_RISE, 32'h0);
            wr(gb + `SES_OPER_FALL, 32'h0);
            pins(a);
            rd(gb + `SES_OPER_COND, {17'h0, a[14:0]});
            rd(gb + `SES_OPER_EVENT, {16'h0, (~a & b & r | a & ~b & f) & 16'h7FFF});
            rd(gb + `SES_OPER_EVENT, 32'h0);
            wr(gb + `SES_OPER_ENAB, {16'h0, r});
            rd(gb + `SES_OPER_ENAB, {17'h0, r[14:0]});
            rd(gb + `SES_OPER_ENAB, {17'h0, r[14:0]});
        end
        g = 0;
        // summary into status byte, service request and interrupt
        wr(`SES_OPER_RISE, 32'h10);
        wr(`SES_OPER_ENAB, 32'h10);
        wr(`SES_QUES_ENAB, 32'h0);
        wr(`SES_SRE, 32'h80);
        wr(`SES_IRQ_MASK, 32'h1);
        pins(16'h0);
        wr(`SES_CTRL, 32'h1);
        wr(`SES_IRQ_STAT, 32'h7);
        rd(`SES_IRQ_STAT, 32'h0);
        pins(16'h10);
        chk(serviceRequest, 32'h1);
        chk(irq, 32'h1);
        rd(`SES_STB, 32'hC0);
        wr(`SES_IRQ_MASK, 32'h0);
        chk(irq, 32'h0);
        rd(`SES_OPER_EVENT, 32'h10);
        pins(16'h10);
        chk(serviceRequest, 32'h0);
        rd(`SES_STB, 32'h0);
        wr(`SES_IRQ_STAT, 32'h7);
        rd(`SES_IRQ_STAT, 32'h0);
        wr(`SES_SRE, 32'hFF);
        rd(`SES_SRE, 32'hBF);
        wr(`SES_OPER_ENAB, 32'h0);
        msgWaitingPin <= 1'b1;
        pins(16'h0);
        chk(serviceRequest, 32'h1);
        rd(`SES_STB, 32'h50);
        wr(`SES_OPER_FALL, 32'h5);
        wr(`SES_QUES_FALL, 32'h5);
        wr(`SES_CTRL, 32'h2);
        rd(`SES_QUES_RISE, 32'h7FFF);
        rd(`SES_QUES_FALL, 32'h0);
        rd(`SES_OPER_FALL, 32'h0);
        g = 1;
        wr(`SES_QUES_ENAB, 32'h1);
        pins(16'h0);
        pins(16'h1);
        rd(`SES_STB, 32'h58);
        rd(`SES_QUES_EVENT, 32'h1);
        repeat (3) @(posedge clk_sys);
        complete_run;
    end
endmodule
bind ses_top ses_top_sva u_ses_top_sva (.clk_sys(clk_sys), .rstn(rstn),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .serviceRequest(serviceRequest), .irq(irq));
`default_nettype wire
